/* File: design/i2c_link_pkg.sv */
// shared constants, types and decode helpers for the two-wire register port
// Behaviour
// RULE1 - slave works at 100kb/s and 400kb/s
// RULE2 - answers as slave, 7-bit address, default 0x2B
// RULE3 - programmed store location 0x04 overrides address
// RULE4 - host writes anytime; core applies at next phase
// RULE5 - write: address+0, pointer byte, data, all acked
// RULE6 - master may continue data bytes until stop
// RULE7 - pointer advances after each written data byte
// RULE8 - read: write pointer, repeated start, address+1
// RULE9 - device acks, returns byte; each ack, next
// RULE10 - master ends read with nack then stop
// RULE11 - bursts start at pointer, auto increment both ways
// RULE12 - status read-only; control and gateway read/write
// RULE13 - host reloads volatile parameters after power-down
// RULE14 - reading interrupt source clears flags, releases line
// RULE15 - foreign addresses are neither acked nor obeyed
package i2c_link_pkg;

	typedef logic [7:0] byte_t;
	typedef logic [6:0] dev_addr_t;

	localparam dev_addr_t DEV_ADDR_DEFAULT = 7'h2B;
	localparam byte_t NVM_ADDR_LOC = 8'h04;

	localparam byte_t REG_IRQ_SRC = 8'h00;
	localparam byte_t STAT_FIRST = 8'h01;
	localparam byte_t STAT_LAST = 8'h08;
	localparam byte_t CTRL_FIRST = 8'h09;
	localparam byte_t CTRL_LAST = 8'h0E;
	localparam byte_t REG_FILE_LAST = 8'h0F;
	localparam byte_t IRQ_SRC_RESET = 8'h00;

	localparam int CLK_PERIOD_NS = 4;
	localparam int QTR_STD_NS = 2500;
	localparam int QTR_FAST_NS = 625;
	localparam logic [9:0] QTR_STD_CYC = 10'((QTR_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [9:0] QTR_FAST_CYC = 10'((QTR_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	function automatic logic is_ctrl(input byte_t a);
		is_ctrl = (a >= CTRL_FIRST) && (a <= CTRL_LAST);
	endfunction

	function automatic logic is_status(input byte_t a);
		is_status = (a >= STAT_FIRST) && (a <= STAT_LAST);
	endfunction

endpackage

/* File: design/i2c_link_if.sv */
// two-wire link between bus master and register slave, open-drain resolved
`timescale 1ns/1ns
interface i2c_link_if;
	logic scl_h_o;
	logic scl_h_oe_n;
	logic sda_h_o;
	logic sda_h_oe_n;
	logic scl_d_o;
	logic scl_d_oe_n;
	logic sda_d_o;
	logic sda_d_oe_n;
	logic scl;
	logic sda;

	// pulled up; an enabled driver with a low output pulls the line low
	assign scl = (scl_h_oe_n | scl_h_o) & (scl_d_oe_n | scl_d_o);
	assign sda = (sda_h_oe_n | sda_h_o) & (sda_d_oe_n | sda_d_o);

	modport host (
		output scl_h_o,
		output scl_h_oe_n,
		output sda_h_o,
		output sda_h_oe_n,
		input scl,
		input sda
	);

	modport device (
		output scl_d_o,
		output scl_d_oe_n,
		output sda_d_o,
		output sda_d_oe_n,
		input scl,
		input sda
	);
endinterface

/* File: design/i2c_dev_end.sv */
// register slave end: protocol on the link clock, core-facing ports on clk_i
`timescale 1ns/1ns
module i2c_dev_end (
	// core clock domain
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// link clock domain
	input wire logic link_clk_i,
	i2c_link_if.device link,
	// address strap from the nonvolatile store
	input wire logic nvm_addr_valid_i,
	input wire i2c_link_pkg::dev_addr_t nvm_addr_i,
	// accepted host writes toward the core
	output logic wr_valid_o,
	output i2c_link_pkg::byte_t wr_addr_o,
	output i2c_link_pkg::byte_t wr_data_o,
	input wire logic wr_ready_i,
	// status and interrupt updates from the core
	input wire logic stat_valid_i,
	input wire i2c_link_pkg::byte_t stat_addr_i,
	input wire i2c_link_pkg::byte_t stat_data_i,
	output logic stat_ready_o,
	// interrupt line
	output logic irq_out_n_o
);
	import i2c_link_pkg::*;

	typedef enum logic [6:0] {
		ST_IDLE = 7'b0000001,
		ST_ADDR = 7'b0000010,
		ST_AACK = 7'b0000100,
		ST_RX = 7'b0001000,
		ST_RACK = 7'b0010000,
		ST_TX = 7'b0100000,
		ST_TACK = 7'b1000000
	} dev_state_t;

	logic [2:0] rst_sync_reg;
	logic link_rst;
	logic [2:0] scl_sync_reg;
	logic [2:0] sda_sync_reg;
	logic scl_f_reg;
	logic sda_f_reg;
	logic scl_q_reg;
	logic sda_q_reg;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	logic [2:0] nvm_v_sync_reg;
	dev_addr_t nvm_a_sync1_reg;
	dev_addr_t nvm_a_sync2_reg;
	dev_addr_t nvm_a_sync3_reg;
	logic cfg_done_reg;
	dev_addr_t own_addr_reg;
	dev_state_t state_reg;
	byte_t shift_reg;
	logic [3:0] bit_cnt_reg;
	logic rw_reg;
	logic have_ptr_reg;
	logic tack_ack_reg;
	byte_t ptr_reg;
	logic sda_drive_reg;
	logic scl_hold_reg;
	logic pin_lo_reg;
	byte_t file_reg [16];
	byte_t flags_reg;
	logic irq_n_reg;
	byte_t rd_byte;
	logic rx_done;
	logic wr_req;
	logic push;
	logic rx_stall;
	logic tx_load;
	logic [15:0] buf_mem [2];
	logic [1:0] buf_wr_reg;
	logic [1:0] buf_rd_reg;
	logic buf_full;
	logic buf_empty;
	logic xfer_busy_reg;
	logic xfer_req_tgl_reg;
	logic [15:0] xfer_word_reg;
	logic [2:0] xack_sync_reg;
	logic [2:0] xreq_sync_reg;
	logic xreq_seen_reg;
	logic xack_tgl_reg;
	logic wr_valid_reg;
	byte_t wr_addr_reg;
	byte_t wr_data_reg;
	logic stat_busy_reg;
	logic stat_ready_reg;
	logic stat_req_tgl_reg;
	logic [15:0] stat_word_reg;
	logic [2:0] sack_sync_reg;
	logic [2:0] sreq_sync_reg;
	logic sreq_seen_reg;
	logic stat_apply;

	// reset follows sys_rst_i into the link domain
	always_ff @(posedge link_clk_i) begin
		rst_sync_reg <= {rst_sync_reg[1:0], sys_rst_i};
	end
	assign link_rst = rst_sync_reg[2];

	// line filter: a level counts once the last two stages agree
	always_ff @(posedge link_clk_i) begin
		if (link_rst) begin
			scl_sync_reg <= 3'h7;
			sda_sync_reg <= 3'h7;
			scl_f_reg <= 1'b1;
			sda_f_reg <= 1'b1;
			scl_q_reg <= 1'b1;
			sda_q_reg <= 1'b1;
		end else begin
			scl_sync_reg <= {scl_sync_reg[1:0], link.scl};
			sda_sync_reg <= {sda_sync_reg[1:0], link.sda};
			if (scl_sync_reg[1] == scl_sync_reg[2]) begin
				scl_f_reg <= scl_sync_reg[2];
			end
			if (sda_sync_reg[1] == sda_sync_reg[2]) begin
				sda_f_reg <= sda_sync_reg[2];
			end
			scl_q_reg <= scl_f_reg;
			sda_q_reg <= sda_f_reg;
		end
	end

	assign scl_rise = scl_f_reg & ~scl_q_reg;
	assign scl_fall = ~scl_f_reg & scl_q_reg;
	assign start_seen = scl_f_reg & scl_q_reg & sda_q_reg & ~sda_f_reg;
	assign stop_seen = scl_f_reg & scl_q_reg & ~sda_q_reg & sda_f_reg;

	// address strap is caught once, after reset release
	always_ff @(posedge link_clk_i) begin
		nvm_v_sync_reg <= {nvm_v_sync_reg[1:0], nvm_addr_valid_i};
		nvm_a_sync1_reg <= nvm_addr_i;
		nvm_a_sync2_reg <= nvm_a_sync1_reg;
		nvm_a_sync3_reg <= nvm_a_sync2_reg;
		if (link_rst) begin
			cfg_done_reg <= 1'b0;
			own_addr_reg <= DEV_ADDR_DEFAULT; // RULE2
		end else if (!cfg_done_reg && nvm_v_sync_reg[1] == nvm_v_sync_reg[2] &&
				nvm_a_sync2_reg == nvm_a_sync3_reg) begin
			cfg_done_reg <= 1'b1;
			if (nvm_v_sync_reg[2]) begin
				own_addr_reg <= nvm_a_sync3_reg; // RULE3
			end
		end
	end

	assign rd_byte = (ptr_reg == REG_IRQ_SRC) ? flags_reg :
		(ptr_reg <= REG_FILE_LAST) ? file_reg[ptr_reg[3:0]] : 8'h00;
	assign rx_done = (state_reg == ST_RX) && (bit_cnt_reg == 4'h8) && !scl_f_reg;
	assign wr_req = rx_done && have_ptr_reg && is_ctrl(ptr_reg); // RULE12
	assign push = wr_req && !buf_full;
	assign rx_stall = wr_req && buf_full;
	assign tx_load = scl_fall && ((state_reg == ST_AACK && rw_reg) ||
		(state_reg == ST_TACK && tack_ack_reg));

	// protocol engine; start and stop override every state
	always_ff @(posedge link_clk_i) begin
		if (link_rst) begin
			state_reg <= ST_IDLE;
			shift_reg <= 8'h00;
			bit_cnt_reg <= 4'h0;
			rw_reg <= 1'b0;
			have_ptr_reg <= 1'b0;
			tack_ack_reg <= 1'b0;
			ptr_reg <= 8'h00;
			sda_drive_reg <= 1'b0;
		end else if (stop_seen) begin
			state_reg <= ST_IDLE;
			sda_drive_reg <= 1'b0;
		end else if (start_seen) begin
			state_reg <= ST_ADDR;
			bit_cnt_reg <= 4'h0;
			sda_drive_reg <= 1'b0;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					sda_drive_reg <= 1'b0;
				end
				ST_ADDR: begin
					if (scl_rise) begin
						shift_reg <= {shift_reg[6:0], sda_f_reg};
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end else if (bit_cnt_reg == 4'h8 && !scl_f_reg) begin
						if (shift_reg[7:1] == own_addr_reg) begin
							sda_drive_reg <= 1'b1; // RULE5
							rw_reg <= shift_reg[0];
							state_reg <= ST_AACK;
						end else begin
							state_reg <= ST_IDLE; // RULE15
						end
					end
				end
				ST_AACK: begin
					if (scl_fall) begin
						bit_cnt_reg <= 4'h0;
						if (rw_reg) begin
							shift_reg <= rd_byte; // RULE9
							sda_drive_reg <= ~rd_byte[7];
							state_reg <= ST_TX;
						end else begin
							sda_drive_reg <= 1'b0;
							have_ptr_reg <= 1'b0;
							state_reg <= ST_RX;
						end
					end
				end
				ST_RX: begin
					if (scl_rise) begin
						shift_reg <= {shift_reg[6:0], sda_f_reg};
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end else if (rx_done && !rx_stall) begin
						sda_drive_reg <= 1'b1; // RULE6
						state_reg <= ST_RACK;
						if (have_ptr_reg) begin
							ptr_reg <= ptr_reg + 8'h01; // RULE7
						end else begin
							ptr_reg <= shift_reg; // RULE11
							have_ptr_reg <= 1'b1;
						end
					end
				end
				ST_RACK: begin
					if (scl_fall) begin
						sda_drive_reg <= 1'b0;
						bit_cnt_reg <= 4'h0;
						state_reg <= ST_RX;
					end
				end
				ST_TX: begin
					if (scl_rise) begin
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end else if (scl_fall) begin
						if (bit_cnt_reg == 4'h8) begin
							sda_drive_reg <= 1'b0;
							state_reg <= ST_TACK;
						end else begin
							shift_reg <= {shift_reg[6:0], 1'b0};
							sda_drive_reg <= ~shift_reg[6];
						end
					end
				end
				ST_TACK: begin
					if (scl_rise) begin
						tack_ack_reg <= ~sda_f_reg;
						if (!sda_f_reg) begin
							ptr_reg <= ptr_reg + 8'h01; // RULE11
						end
					end else if (scl_fall) begin
						bit_cnt_reg <= 4'h0;
						if (tack_ack_reg) begin
							shift_reg <= rd_byte; // RULE9
							sda_drive_reg <= ~rd_byte[7];
							state_reg <= ST_TX;
						end else begin
							state_reg <= ST_IDLE;
						end
					end
				end
			endcase
		end
	end

	// full buffer holds the clock low instead of dropping the byte
	always_ff @(posedge link_clk_i) begin
		if (link_rst) begin
			scl_hold_reg <= 1'b0;
			pin_lo_reg <= 1'b0;
		end else begin
			// keep the clock one more cycle so the ack bit settles before the clock rises
			scl_hold_reg <= rx_stall | (scl_hold_reg & (state_reg == ST_RX));
			pin_lo_reg <= 1'b0;
		end
	end

	assign link.scl_d_o = pin_lo_reg;
	assign link.sda_d_o = pin_lo_reg;
	assign link.scl_d_oe_n = ~scl_hold_reg;
	assign link.sda_d_oe_n = ~sda_drive_reg;

	// register file: only control and gateway bytes take host writes
	always_ff @(posedge link_clk_i) begin
		if (link_rst) begin
			for (int i = 0; i < 16; i++) begin
				file_reg[i] <= 8'h00;
			end
		end else begin
			if (push) begin
				file_reg[ptr_reg[3:0]] <= shift_reg; // RULE12
			end
			// host bytes and core status never share an index, so both may land at once
			if (stat_apply && is_status(stat_word_reg[15:8])) begin
				file_reg[stat_word_reg[11:8]] <= stat_word_reg[7:0];
			end
		end
	end

	// a new event wins over the clear caused by the same read
	always_ff @(posedge link_clk_i) begin
		if (link_rst) begin
			flags_reg <= IRQ_SRC_RESET;
			irq_n_reg <= 1'b1;
		end else begin
			flags_reg <= (flags_reg & ~((tx_load && ptr_reg == REG_IRQ_SRC) ? 8'hFF : 8'h00)) |
				((stat_apply && stat_word_reg[15:8] == REG_IRQ_SRC) ? stat_word_reg[7:0] : 8'h00); // RULE14
			irq_n_reg <= ~|flags_reg; // RULE14
		end
	end
	assign irq_out_n_o = irq_n_reg;

	assign buf_full = (buf_wr_reg ^ buf_rd_reg) == 2'b10;
	assign buf_empty = buf_wr_reg == buf_rd_reg;

	// two-entry write buffer drained one word at a time over a toggle handshake
	always_ff @(posedge link_clk_i) begin
		if (link_rst) begin
			buf_wr_reg <= 2'h0;
			buf_rd_reg <= 2'h0;
			xfer_busy_reg <= 1'b0;
			xfer_req_tgl_reg <= 1'b0;
			xfer_word_reg <= 16'h0000;
			xack_sync_reg <= 3'h0;
		end else begin
			xack_sync_reg <= {xack_sync_reg[1:0], xack_tgl_reg};
			if (push) begin
				buf_mem[buf_wr_reg[0]] <= {ptr_reg, shift_reg}; // RULE4
				buf_wr_reg <= buf_wr_reg + 2'h1;
			end
			if (!xfer_busy_reg && !buf_empty) begin
				xfer_word_reg <= buf_mem[buf_rd_reg[0]];
				buf_rd_reg <= buf_rd_reg + 2'h1;
				xfer_req_tgl_reg <= ~xfer_req_tgl_reg;
				xfer_busy_reg <= 1'b1;
			end else if (xfer_busy_reg && xack_sync_reg[1] == xack_sync_reg[2] &&
					xack_sync_reg[2] == xfer_req_tgl_reg) begin
				xfer_busy_reg <= 1'b0;
			end
		end
	end

	// core side: word held stable by the busy flag until acknowledged
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			xreq_sync_reg <= 3'h0;
			xreq_seen_reg <= 1'b0;
			xack_tgl_reg <= 1'b0;
			wr_valid_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			wr_data_reg <= 8'h00;
		end else begin
			xreq_sync_reg <= {xreq_sync_reg[1:0], xfer_req_tgl_reg};
			if (wr_valid_reg && wr_ready_i) begin
				wr_valid_reg <= 1'b0;
				xack_tgl_reg <= xreq_seen_reg;
			end else if (!wr_valid_reg && xreq_sync_reg[1] == xreq_sync_reg[2] &&
					xreq_sync_reg[2] != xreq_seen_reg) begin
				wr_valid_reg <= 1'b1;
				wr_addr_reg <= xfer_word_reg[15:8];
				wr_data_reg <= xfer_word_reg[7:0];
				xreq_seen_reg <= xreq_sync_reg[2];
			end
		end
	end
	assign wr_valid_o = wr_valid_reg;
	assign wr_addr_o = wr_addr_reg;
	assign wr_data_o = wr_data_reg;

	// status updates cross the other way with the same handshake
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			stat_busy_reg <= 1'b0;
			stat_ready_reg <= 1'b0;
			stat_req_tgl_reg <= 1'b0;
			stat_word_reg <= 16'h0000;
			sack_sync_reg <= 3'h0;
		end else begin
			sack_sync_reg <= {sack_sync_reg[1:0], sreq_seen_reg};
			if (stat_ready_reg && stat_valid_i) begin
				stat_word_reg <= {stat_addr_i, stat_data_i};
				stat_req_tgl_reg <= ~stat_req_tgl_reg;
				stat_busy_reg <= 1'b1;
				stat_ready_reg <= 1'b0;
			end else if (stat_busy_reg && sack_sync_reg[1] == sack_sync_reg[2] &&
					sack_sync_reg[2] == stat_req_tgl_reg) begin
				stat_busy_reg <= 1'b0;
				stat_ready_reg <= 1'b1;
			end else if (!stat_busy_reg) begin
				stat_ready_reg <= 1'b1;
			end
		end
	end
	assign stat_ready_o = stat_ready_reg;

	always_ff @(posedge link_clk_i) begin
		if (link_rst) begin
			sreq_sync_reg <= 3'h0;
			sreq_seen_reg <= 1'b0;
		end else begin
			sreq_sync_reg <= {sreq_sync_reg[1:0], stat_req_tgl_reg};
			if (stat_apply) begin
				sreq_seen_reg <= sreq_sync_reg[2];
			end
		end
	end
	assign stat_apply = (sreq_sync_reg[1] == sreq_sync_reg[2]) &&
		(sreq_sync_reg[2] != sreq_seen_reg);

endmodule

/* File: design/i2c_host_end.sv */
// bus master end: drives the link clock from clk_i and runs register bursts
`timescale 1ns/1ns
module i2c_host_end (
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// link
	i2c_link_if.host link,
	// command
	input wire logic cmd_valid_i,
	output logic cmd_ready_o,
	input wire logic cmd_read_i,
	input wire logic fast_mode_i,
	input wire i2c_link_pkg::dev_addr_t cmd_dev_i,
	input wire i2c_link_pkg::byte_t cmd_reg_i,
	input wire logic [3:0] cmd_len_i,
	// write data
	input wire logic wdata_valid_i,
	output logic wdata_ready_o,
	input wire i2c_link_pkg::byte_t wdata_i,
	// read data and completion
	output logic rdata_valid_o,
	output i2c_link_pkg::byte_t rdata_o,
	output logic done_o,
	output logic nack_o
);
	import i2c_link_pkg::*;

	typedef enum logic [4:0] {
		H_IDLE = 5'b00001,
		H_START = 5'b00010,
		H_BIT = 5'b00100,
		H_LOAD = 5'b01000,
		H_STOP = 5'b10000
	} host_state_t;

	typedef enum logic [4:0] {
		SQ_ADDRW = 5'b00001,
		SQ_REG = 5'b00010,
		SQ_WDATA = 5'b00100,
		SQ_ADDRR = 5'b01000,
		SQ_RDATA = 5'b10000
	} seq_t;

	host_state_t state_reg;
	seq_t seq_reg;
	logic [2:0] scl_sync_reg;
	logic [2:0] sda_sync_reg;
	logic scl_in_reg;
	logic sda_in_reg;
	logic [9:0] tick_reg;
	logic tick;
	logic [1:0] qtr_reg;
	logic [3:0] bit_reg;
	byte_t sh_reg;
	logic samp_reg;
	logic rd_reg;
	dev_addr_t dev_reg;
	byte_t regp_reg;
	logic [3:0] cnt_reg;
	logic scl_oe_n_reg;
	logic sda_oe_n_reg;
	logic pin_lo_reg;
	logic cmd_ready_reg;
	logic wdata_ready_reg;
	logic rdata_valid_reg;
	byte_t rdata_reg;
	logic done_reg;
	logic nack_reg;
	logic out_bit;
	logic tx_byte;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			scl_sync_reg <= 3'h7;
			sda_sync_reg <= 3'h7;
			scl_in_reg <= 1'b1;
			sda_in_reg <= 1'b1;
		end else begin
			scl_sync_reg <= {scl_sync_reg[1:0], link.scl};
			sda_sync_reg <= {sda_sync_reg[1:0], link.sda};
			if (scl_sync_reg[1] == scl_sync_reg[2]) begin
				scl_in_reg <= scl_sync_reg[2];
			end
			if (sda_sync_reg[1] == sda_sync_reg[2]) begin
				sda_in_reg <= sda_sync_reg[2];
			end
		end
	end

	// quarter-bit divider sets the link rate
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || tick_reg == 10'h000) begin
			tick_reg <= fast_mode_i ? QTR_FAST_CYC - 10'h001 : QTR_STD_CYC - 10'h001; // RULE1
		end else begin
			tick_reg <= tick_reg - 10'h001;
		end
	end
	assign tick = (tick_reg == 10'h000);

	assign tx_byte = (seq_reg != SQ_RDATA);
	// ack slot: release for the slave, or ack every read byte but the last
	assign out_bit = (bit_reg == 4'h8) ? (tx_byte | (cnt_reg == 4'h0)) : (!tx_byte | sh_reg[7]); // RULE10

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_reg <= H_IDLE;
			seq_reg <= SQ_ADDRW;
			qtr_reg <= 2'h0;
			bit_reg <= 4'h0;
			sh_reg <= 8'h00;
			samp_reg <= 1'b1;
			rd_reg <= 1'b0;
			dev_reg <= 7'h00;
			regp_reg <= 8'h00;
			cnt_reg <= 4'h0;
			scl_oe_n_reg <= 1'b1;
			sda_oe_n_reg <= 1'b1;
			pin_lo_reg <= 1'b0;
			cmd_ready_reg <= 1'b0;
			wdata_ready_reg <= 1'b0;
			rdata_valid_reg <= 1'b0;
			rdata_reg <= 8'h00;
			done_reg <= 1'b0;
			nack_reg <= 1'b0;
		end else begin
			rdata_valid_reg <= 1'b0;
			done_reg <= 1'b0;
			pin_lo_reg <= 1'b0;
			unique case (state_reg)
				H_IDLE: begin
					cmd_ready_reg <= 1'b1;
					if (cmd_ready_reg && cmd_valid_i) begin
						cmd_ready_reg <= 1'b0;
						rd_reg <= cmd_read_i;
						dev_reg <= cmd_dev_i;
						regp_reg <= cmd_reg_i;
						cnt_reg <= cmd_len_i;
						nack_reg <= 1'b0;
						seq_reg <= SQ_ADDRW;
						qtr_reg <= 2'h0;
						state_reg <= H_START;
					end
				end
				H_START: begin
					if (tick) begin
						qtr_reg <= qtr_reg + 2'h1;
						unique case (qtr_reg)
							2'h0: sda_oe_n_reg <= 1'b1;
							2'h1: scl_oe_n_reg <= 1'b1;
							2'h2: begin
								if (scl_in_reg) begin
									sda_oe_n_reg <= 1'b0;
								end else begin
									qtr_reg <= qtr_reg;
								end
							end
							2'h3: begin
								scl_oe_n_reg <= 1'b0;
								bit_reg <= 4'h0;
								sh_reg <= {dev_reg, seq_reg == SQ_ADDRR}; // RULE8
								state_reg <= H_BIT;
							end
						endcase
					end
				end
				H_BIT: begin
					if (tick) begin
						qtr_reg <= qtr_reg + 2'h1;
						unique case (qtr_reg)
							2'h0: sda_oe_n_reg <= out_bit;
							2'h1: scl_oe_n_reg <= 1'b1;
							2'h2: begin
								// slave may stretch the low phase
								if (scl_in_reg) begin
									samp_reg <= sda_in_reg;
								end else begin
									qtr_reg <= qtr_reg;
								end
							end
							2'h3: begin
								scl_oe_n_reg <= 1'b0;
								bit_reg <= bit_reg + 4'h1;
								if (bit_reg != 4'h8) begin
									sh_reg <= {sh_reg[6:0], samp_reg};
								end
								if (bit_reg == 4'h7) begin
									rdata_reg <= {sh_reg[6:0], samp_reg};
								end
								if (bit_reg == 4'h8) begin
									bit_reg <= 4'h0;
									qtr_reg <= 2'h0;
									if (tx_byte && samp_reg) begin
										nack_reg <= 1'b1; // RULE15
										state_reg <= H_STOP;
									end else begin
										unique case (seq_reg)
											SQ_ADDRW: begin
												sh_reg <= regp_reg; // RULE5
												seq_reg <= SQ_REG;
											end
											SQ_REG: begin
												if (rd_reg) begin
													seq_reg <= SQ_ADDRR; // RULE8
													state_reg <= H_START;
												end else begin
													seq_reg <= SQ_WDATA;
													wdata_ready_reg <= 1'b1;
													state_reg <= H_LOAD;
												end
											end
											SQ_WDATA: begin
												if (cnt_reg == 4'h0) begin
													state_reg <= H_STOP;
												end else begin
													cnt_reg <= cnt_reg - 4'h1; // RULE6
													wdata_ready_reg <= 1'b1;
													state_reg <= H_LOAD;
												end
											end
											SQ_ADDRR: begin
												seq_reg <= SQ_RDATA;
											end
											SQ_RDATA: begin
												rdata_valid_reg <= 1'b1; // RULE9
												if (cnt_reg == 4'h0) begin
													state_reg <= H_STOP; // RULE10
												end else begin
													cnt_reg <= cnt_reg - 4'h1;
												end
											end
										endcase
									end
								end
							end
						endcase
					end
				end
				H_LOAD: begin
					// clock stays low while the user supplies the next byte
					if (wdata_ready_reg && wdata_valid_i) begin
						wdata_ready_reg <= 1'b0;
						sh_reg <= wdata_i;
						qtr_reg <= 2'h0;
						state_reg <= H_BIT;
					end
				end
				H_STOP: begin
					if (tick) begin
						qtr_reg <= qtr_reg + 2'h1;
						unique case (qtr_reg)
							2'h0: sda_oe_n_reg <= 1'b0;
							2'h1: scl_oe_n_reg <= 1'b1;
							2'h2: begin
								if (scl_in_reg) begin
									sda_oe_n_reg <= 1'b1;
								end else begin
									qtr_reg <= qtr_reg;
								end
							end
							2'h3: begin
								done_reg <= 1'b1;
								state_reg <= H_IDLE;
							end
						endcase
					end
				end
			endcase
		end
	end

	assign link.scl_h_o = pin_lo_reg;
	assign link.sda_h_o = pin_lo_reg;
	assign link.scl_h_oe_n = scl_oe_n_reg;
	assign link.sda_h_oe_n = sda_oe_n_reg;
	assign cmd_ready_o = cmd_ready_reg;
	assign wdata_ready_o = wdata_ready_reg;
	assign rdata_valid_o = rdata_valid_reg;
	assign rdata_o = rdata_reg;
	assign done_o = done_reg;
	assign nack_o = nack_reg;

endmodule

/* File: test/i2c_link_chk.sv */
// link timing and line ownership checks
`timescale 1ns/1ns
module i2c_link_chk (
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// link lines
	input wire logic sda_h_oe_n,
	input wire logic scl_d_oe_n,
	input wire logic sda_d_oe_n,
	input wire logic scl,
	input wire logic sda
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	property p_rel; $fell(sys_rst_i) |-> scl_d_oe_n & sda_d_oe_n & sda_h_oe_n; endproperty
	a_rel: assert property (p_rel) else $error("line held at release");
	property p_idle; $fell(sys_rst_i) |-> (scl & sda) [*8]; endproperty
	a_idle: assert property (p_idle) else $error("bus busy at release");
	// the slave may move its data line only while the clock is low
	property p_dsda; $changed(sda_d_oe_n) |-> !scl && !$past(scl); endproperty
	a_dsda: assert property (p_dsda) else $error("slave data moved");
	property p_dscl; $fell(scl_d_oe_n) |-> !$past(scl); endproperty
	a_dscl: assert property (p_dscl) else $error("slave cut a high clock");
	property p_str; $fell(scl_d_oe_n) |-> ##[1:1000] scl_d_oe_n; endproperty
	a_str: assert property (p_str) else $error("stretch too long");
	property p_high; $rose(scl) |-> ##150 scl; endproperty
	a_high: assert property (p_high) else $error("clock high too short");
	property p_low; $fell(scl) |-> ##150 !scl; endproperty
	a_low: assert property (p_low) else $error("clock low too short");
	property p_start; scl && $fell(sda) |-> !sda_h_oe_n; endproperty
	a_start: assert property (p_start) else $error("start not by master");
	c_ack: cover property ($fell(sda_d_oe_n));
	c_str: cover property ($fell(scl_d_oe_n));
	c_start: cover property (scl && $fell(sda));
endmodule

/* File: test/i2c_slave_register_access_test.sv */
// bench: master end and slave end joined on one link, self checking
`timescale 1ns/1ns
module i2c_slave_register_access_test;
	import i2c_link_pkg::*;
	logic clk_i = 1'b0, link_clk_i = 1'b0, sys_rst_i = 1'b1, nvm_addr_valid_i = 1'b1;
	logic wr_ready_i = 1'b0, stat_valid_i = 1'b0, cmd_valid_i = 1'b0, cmd_read_i = 1'b0;
	logic fast_mode_i = 1'b1, wdata_valid_i = 1'b0, ct, wt, fin;
	logic wr_valid_o, stat_ready_o, irq_out_n_o, cmd_ready_o, wdata_ready_o, rdata_valid_o;
	logic done_o, nack_o;
	dev_addr_t nvm_addr_i = 7'h35, cmd_dev_i = 7'h00;
	byte_t stat_addr_i = 8'h00, stat_data_i = 8'h00, cmd_reg_i = 8'h00, wdata_i = 8'h00;
	byte_t wr_addr_o, wr_data_o, rdata_o, flags, s1, s2, wq[$], rq[$], d[$];
	logic [3:0] cmd_len_i = 4'h0;
	logic [15:0] got[$];
	int n_errors = 0, samples_checked = 0, seed = 32'h430EAB11, k;

	i2c_link_if lk();
	i2c_host_end i_i2c_host_end (.link(lk.host), .*);
	i2c_dev_end i_i2c_dev_end (.link(lk.device), .*);
	i2c_link_chk i_i2c_link_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl(lk.scl),
		.sda(lk.sda), .sda_h_oe_n(lk.sda_h_oe_n), .scl_d_oe_n(lk.scl_d_oe_n),
		.sda_d_oe_n(lk.sda_d_oe_n));

	initial forever #2 clk_i = ~clk_i;
	initial #7 forever #40 link_clk_i = ~link_clk_i;

	// the core refuses words until the slave has to stretch, so the buffer fills first
	always @(posedge clk_i) begin
		if (wr_valid_o && wr_ready_i)
			got.push_back({wr_addr_o, wr_data_o});
		if (!lk.scl_d_oe_n)
			wr_ready_i <= 1'b1;
	end

	function automatic logic [15:0] exp_word(input byte_t base, input int i, input byte_t v);
		exp_word = {8'(base + 8'(i)), v};
	endfunction

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		if (n_errors == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic limit(input logic hit);
		if (hit) begin
			n_errors++;
			conclude();
		end
	endtask

	task automatic upd(input byte_t a, input byte_t v);
		@(posedge clk_i);
		{stat_valid_i, stat_addr_i, stat_data_i} <= {1'b1, a, v};
		k = 0;
		do @(negedge clk_i); while (!stat_ready_o && ++k < 400);
		limit(k >= 400);
		@(posedge clk_i);
		stat_valid_i <= 1'b0;
	endtask

	task automatic run(input dev_addr_t a, input logic rd, input byte_t r, input logic [3:0] n,
		input logic f);
		fast_mode_i <= f;
		repeat (4) @(posedge clk_i);
		{cmd_dev_i, cmd_read_i, cmd_reg_i, cmd_len_i, cmd_valid_i} <= {a, rd, r, n, 1'b1};
		wdata_valid_i <= wq.size() > 0;
		wdata_i <= wq.size() > 0 ? wq[0] : 8'h00;
		rq.delete();
		fin = 1'b0;
		for (k = 0; k < 45000 && !fin; k++) begin
			@(negedge clk_i);
			{fin, ct, wt} = {done_o, cmd_valid_i & cmd_ready_o, wdata_valid_i & wdata_ready_o};
			if (rdata_valid_o)
				rq.push_back(rdata_o);
			@(posedge clk_i);
			if (ct)
				cmd_valid_i <= 1'b0;
			if (wt) begin
				wq.delete(0);
				wdata_valid_i <= wq.size() > 0;
				wdata_i <= wq.size() > 0 ? wq[0] : 8'h00;
			end
		end
		limit(!fin);
	endtask

	initial begin
		repeat (120) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		repeat (300) @(posedge clk_i);
		flags = (8'($random(seed)) & 8'h7F) | 8'h01;
		s1 = 8'($random(seed));
		s2 = 8'($random(seed));
		upd(REG_IRQ_SRC, flags);
		upd(STAT_FIRST, s1);
		upd(8'h02, s2);
		repeat (200) @(posedge clk_i);
		check(16'(irq_out_n_o), 16'h0000);
		run(DEV_ADDR_DEFAULT, 1'b0, 8'h0C, 4'h0, 1'b0);
		check({7'h00, nack_o, 8'(got.size())}, 16'h0100);
		// four control bytes: the fourth finds the buffer full and is stretched
		repeat (4) wq.push_back(8'($random(seed)));
		d = wq;
		run(nvm_addr_i, 1'b0, 8'h0B, 4'h3, 1'b1);
		repeat (200) @(posedge clk_i);
		check({7'h00, nack_o, 8'(got.size())}, 16'h0004);
		for (int i = 0; i < 4; i++)
			check(got[i], exp_word(8'h0B, i, d[i]));
		run(nvm_addr_i, 1'b1, REG_IRQ_SRC, 4'h2, 1'b1);
		check({rq[0], rq[1]}, {flags, s1});
		check({rq[2], 8'(rq.size())}, {s2, 8'h03});
		check({7'h00, nack_o, 7'h00, irq_out_n_o}, 16'h0001);
		conclude();
	end
endmodule
